// ===== rtl/pcs_pll_ctrl.sv
// digital control of the clock synthesizer plus the clock selector array
// assumes fabric clocks arrive asynchronous and are sampled at 50 MHz
`timescale 1ns/1ns
`default_nettype none
module pcs_pll_ctrl
	import pcs_pkg::*;
#(
	parameter int unsigned LOCK_CNT = LOCK_CYCLES,
	parameter int unsigned SEL_N = NUM_SEL
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_pll_rst,
	input wire logic i_reference_clock_in,
	input wire logic i_feedback_clock_in,
	input wire pcs_pkg::pcs_fb_src_t i_fb_src,
	input wire pcs_pkg::pcs_div_t i_div,
	input wire pcs_pkg::pcs_delay_t i_static_delay,
	input wire logic i_dyn_delay_enable,
	input wire logic i_dyn_delay_zero_in,
	input wire logic i_dyn_delay_direction_in,
	input wire logic [pcs_pkg::DLY_W-1:0] i_dyn_delay_value_in,
	input wire logic [SEL_N-1:0] i_sel_clk_a,
	input wire logic [SEL_N-1:0] i_sel_clk_b,
	input wire logic [SEL_N-1:0] i_sel,
	output logic o_lock,
	output logic o_primary_clock_out,
	output logic o_shifted_clock_out,
	output logic o_divided_clock_out,
	output logic o_dyn_delay_zero_out,
	output logic o_dyn_delay_direction_out,
	output logic [pcs_pkg::DLY_W-1:0] o_dyn_delay_value_out,
	output logic [SEL_N-1:0] o_sel_clk,
	output logic [SEL_N-1:0] o_sel_active
);
	import pcs_pkg::*;

	if (LOCK_CNT < 1 || SEL_N < 2 || SEL_N % 2 != 0) begin : g_bad_param
		$error("pcs_pll_ctrl: bad parameters");
	end

	localparam int unsigned CW = $clog2(LOCK_CNT + 1);
	localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CNT);

	function automatic logic [DIV_W-1:0] div_safe(input logic [DIV_W-1:0] d);
		return (d == '0) ? DIV_ONE : d;
	endfunction

	logic rst_s1, rst_s2;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	wire logic rst_n = rst_s2;

	// two flip-flops on every asynchronous input before logic reads it
	localparam int unsigned SW = 6 + DLY_W;
	logic [SW-1:0] sy1, sy2;
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1 <= '0;
			sy2 <= '0;
		end else begin
			sy1 <= {i_pll_rst, i_reference_clock_in, i_feedback_clock_in,
				i_dyn_delay_enable, i_dyn_delay_zero_in,
				i_dyn_delay_direction_in, i_dyn_delay_value_in};
			sy2 <= sy1;
		end
	end
	logic s_prst, s_ref, s_fb, s_mode;
	pcs_delay_t s_pin;
	assign {s_prst, s_ref, s_fb, s_mode, s_pin} = sy2;

	// delay selection and status
	pcs_delay_t eff, next_eff;
	always_comb begin
		next_eff = s_mode ? s_pin : i_static_delay;
		if (next_eff.zero)
			next_eff.value = STATIC_DLY_RESET;
	end

	// reference edge detection, input divider and post divider
	logic ref_d, fb_d;
	logic [DIV_W-1:0] in_cnt, next_in_cnt;
	logic [DIV_W-1:0] post_cnt, next_post_cnt;
	logic [DIV_W-1:0] sec_cnt, next_sec_cnt;
	logic pri, next_pri, sec, next_sec, shf, next_shf;
	logic [DLY_W-1:0] ph_cnt, next_ph_cnt;
	logic [CW-1:0] lock_cnt, next_lock_cnt;
	logic fb_seen, next_fb_seen;
	wire logic ref_rise = s_ref & ~ref_d;
	wire logic fb_rise = s_fb & ~fb_d;
	logic pfd_tick, fb_ok;

	always_comb begin
		next_in_cnt = in_cnt;
		pfd_tick = 1'b0;
		if (ref_rise) begin
			if (in_cnt >= div_safe(i_div.in_div) - DIV_ONE) begin
				next_in_cnt = '0;
				pfd_tick = 1'b1;
			end else
				next_in_cnt = in_cnt + DIV_ONE;
		end
		// oscillator steps every reference clock cycle, post divider slows it
		next_post_cnt = post_cnt + DIV_ONE;
		next_pri = pri;
		if (post_cnt >= div_safe(i_div.post_div) - DIV_ONE) begin
			next_post_cnt = '0;
			next_pri = ~pri;
		end
		next_sec_cnt = sec_cnt;
		next_sec = sec;
		if (next_pri != pri) begin
			if (sec_cnt >= div_safe(i_div.sec_div) - DIV_ONE) begin
				next_sec_cnt = '0;
				next_sec = ~sec;
			end else
				next_sec_cnt = sec_cnt + DIV_ONE;
		end
		// shifted copy: lead pre-toggles, lag delays toggle
		next_ph_cnt = ph_cnt;
		next_shf = shf;
		if (eff.value == '0) begin
			// zero delay realigns at once instead of after a stale count
			next_ph_cnt = '0;
			next_shf = next_pri;
		end else if (next_pri != pri) begin
			next_ph_cnt = eff.value;
			if (eff.lead)
				next_shf = next_pri;
		end else if (ph_cnt != '0) begin
			next_ph_cnt = ph_cnt - 1'b1;
			if (ph_cnt == 3'h1)
				next_shf = eff.lead ? ~pri : pri;
		end
	end

	// feedback source: internal and clock net always count as present, user needs pin edges
	always_comb begin
		unique case (i_fb_src)
			FB_INTERNAL: fb_ok = 1'b1;
			FB_CLOCK_NET: fb_ok = 1'b1;
			FB_USER: fb_ok = fb_seen;
			default: fb_ok = 1'b0;
		endcase
	end

	// feedback evidence survives a missing feedback, else user mode deadlocks
	always_comb begin
		next_fb_seen = fb_seen | fb_rise;
		next_lock_cnt = lock_cnt;
		if (s_prst || next_eff != eff) begin
			next_lock_cnt = '0;
			next_fb_seen = fb_rise;
		end else if (!fb_ok)
			next_lock_cnt = '0;
		else if (pfd_tick && lock_cnt != LOCK_LAST)
			next_lock_cnt = lock_cnt + 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_d <= 1'b0;
			fb_d <= 1'b0;
			in_cnt <= '0;
			post_cnt <= '0;
			sec_cnt <= '0;
			pri <= 1'b0;
			sec <= 1'b0;
			shf <= 1'b0;
			ph_cnt <= '0;
			lock_cnt <= '0;
			fb_seen <= 1'b0;
			eff <= '0;
		end else begin
			ref_d <= s_ref;
			fb_d <= s_fb;
			in_cnt <= next_in_cnt;
			post_cnt <= next_post_cnt;
			sec_cnt <= next_sec_cnt;
			pri <= next_pri;
			sec <= next_sec;
			shf <= next_shf;
			ph_cnt <= next_ph_cnt;
			lock_cnt <= next_lock_cnt;
			fb_seen <= next_fb_seen;
			eff <= next_eff;
		end
	end

	assign o_lock = (lock_cnt == LOCK_LAST) && !s_prst;
	assign o_primary_clock_out = pri;
	assign o_shifted_clock_out = shf;
	assign o_divided_clock_out = sec;
	assign o_dyn_delay_zero_out = eff.zero;
	assign o_dyn_delay_direction_out = eff.lead;
	assign o_dyn_delay_value_out = eff.value;

	// eight independent selectors, the index pairs them by side
	genvar g;
	generate
		for (g = 0; g < SEL_N; g++) begin : g_sel
			logic [1:0] a_s, b_s, l_s;
			always_ff @(posedge i_ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					a_s <= '0;
					b_s <= '0;
					l_s <= '0;
				end else begin
					a_s <= {a_s[0], i_sel_clk_a[g]};
					b_s <= {b_s[0], i_sel_clk_b[g]};
					l_s <= {l_s[0], i_sel[g]};
				end
			end
			pcs_clk_sel u_sel (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(rst_n),
				.i_clk_a(a_s[1]),
				.i_clk_b(b_s[1]),
				.i_sel(l_s[1]),
				.o_clk(o_sel_clk[g]),
				.o_sel_active(o_sel_active[g])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// ===== rtl/pcs_pkg.sv
// shared types and constants for the clock synthesizer control block
// assumes a single 50 MHz reference clock domain
package pcs_pkg;
	localparam int unsigned REF_CLK_MHZ = 50;
	localparam int unsigned LOCK_TIME_US = 100;
	localparam int unsigned LOCK_CYCLES = LOCK_TIME_US * REF_CLK_MHZ;
	localparam int unsigned DLY_W = 3;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned NUM_SEL = 8;
	localparam logic [DLY_W-1:0] STATIC_DLY_RESET = 3'h0;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

	typedef enum logic [1:0] {
		FB_INTERNAL,
		FB_CLOCK_NET,
		FB_USER
	} pcs_fb_src_t;

	typedef struct packed {
		logic zero;
		logic lead;
		logic [DLY_W-1:0] value;
	} pcs_delay_t;

	typedef struct packed {
		logic [DIV_W-1:0] in_div;
		logic [DIV_W-1:0] fb_div;
		logic [DIV_W-1:0] post_div;
		logic [DIV_W-1:0] sec_div;
	} pcs_div_t;
endpackage

// ===== rtl/pcs_clk_sel.sv
// glitchless selector between two clocks, modelled as enable qualified
// outputs in the reference clock domain; inputs are strobes from that domain
`timescale 1ns/1ns
`default_nettype none
module pcs_clk_sel (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_a,
	input wire logic i_clk_b,
	input wire logic i_sel,
	output logic o_clk,
	output logic o_sel_active
);
	logic en_a;
	logic en_b;
	logic next_en_a;
	logic next_en_b;

	// break before make: the new source is enabled only once the old one
	// is off, and enables change only while both sources are low
	always_comb begin
		next_en_a = en_a;
		next_en_b = en_b;
		if (!i_clk_a && !i_clk_b) begin
			next_en_a = !i_sel && !en_b;
			next_en_b = i_sel && !en_a;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_a <= 1'b0;
			en_b <= 1'b0;
		end else begin
			en_a <= next_en_a;
			en_b <= next_en_b;
		end
	end

	assign o_clk = (en_a & i_clk_a) | (en_b & i_clk_b);
	assign o_sel_active = en_b;
endmodule
`default_nettype wire

// ===== tb/pcs_user_model.sv
// fabric-side model: reference, user feedback and selector source clocks
// assumes one free running 50 MHz bench clock; all outputs change on its edge
`timescale 1ns/1ns
`default_nettype none
module pcs_user_model (
	input wire logic i_clk,
	output logic o_ref,
	output logic o_fb,
	output logic [7:0] o_a,
	output logic [7:0] o_b
);
	logic [3:0] cnt = 4'h0;
	always @(posedge i_clk) begin
		cnt <= cnt + 4'h1;
		o_ref <= cnt[1];
		// a single user feedback source mirrors the reference
		o_fb <= cnt[1];
		// long high phases so sampled copies never shrink below two cycles
		o_a <= {8{cnt[2]}};
		o_b <= {8{cnt[3]}};
	end
endmodule
`default_nettype wire

// ===== tb/pcs_pll_ctrl_assertions.sv
// checker on the ports of the synthesizer control top
// assumes the single reference clock domain and its async reset
`timescale 1ns/1ns
`default_nettype none
module pcs_pll_ctrl_assertions
	import pcs_pkg::*;
#(
	parameter int unsigned LOCK_CNT = 4,
	parameter int unsigned SEL_N = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_pll_rst,
	input wire pcs_pkg::pcs_fb_src_t i_fb_src,
	input wire pcs_pkg::pcs_delay_t i_static_delay,
	input wire logic i_dyn_delay_enable,
	input wire logic i_dyn_delay_zero_in,
	input wire logic i_dyn_delay_direction_in,
	input wire logic [pcs_pkg::DLY_W-1:0] i_dyn_delay_value_in,
	input wire logic [SEL_N-1:0] i_sel,
	input wire logic o_lock,
	input wire logic o_primary_clock_out,
	input wire logic o_shifted_clock_out,
	input wire logic o_dyn_delay_zero_out,
	input wire logic o_dyn_delay_direction_out,
	input wire logic [pcs_pkg::DLY_W-1:0] o_dyn_delay_value_out,
	input wire logic [SEL_N-1:0] o_sel_clk,
	input wire logic [SEL_N-1:0] o_sel_active
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	logic [4:0] eff, pin, stat;
	int unsigned since;
	assign eff = {o_dyn_delay_zero_out, o_dyn_delay_direction_out,
		o_dyn_delay_value_out};
	assign pin = {i_dyn_delay_zero_in, i_dyn_delay_direction_in,
		i_dyn_delay_zero_in ? 3'h0 : i_dyn_delay_value_in};
	assign stat = {i_static_delay.zero, i_static_delay.lead,
		i_static_delay.zero ? 3'h0 : i_static_delay.value};
	// cycles since the last restart of locking, saturating
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			since <= 0;
		else if (i_pll_rst || !$stable(eff))
			since <= 0;
		else if (since < LOCK_CNT)
			since <= since + 1;
	end
	chk_lock_wait: assert property ($rose(o_lock) |-> since >= LOCK_CNT)
		else $error("lock rose too early");
	chk_change_drop: assert property (!$stable(eff) |-> !o_lock)
		else $error("lock held over delay change");
	chk_pin_delay: assert property ((i_dyn_delay_enable
		&& $stable(pin) && $stable(i_dyn_delay_enable))[*4]
		|-> eff == pin)
		else $error("pin delay not in effect");
	chk_static_delay: assert property ((!i_dyn_delay_enable
		&& $stable(stat) && $stable(i_dyn_delay_enable))[*4]
		|-> eff == stat)
		else $error("static delay not in effect");
	chk_zero_value: assert property (o_dyn_delay_zero_out
		|-> o_dyn_delay_value_out == 3'h0)
		else $error("zero delay with nonzero value");
	chk_zero_aligned: assert property (o_dyn_delay_zero_out[*8]
		|-> o_shifted_clock_out == o_primary_clock_out)
		else $error("shifted clock moved at zero delay");
	chk_rst_holds: assert property (i_pll_rst[*3] |-> !o_lock)
		else $error("lock high in reset");
	chk_bad_fb: assert property ((i_fb_src == 2'h3)[*8] |-> !o_lock)
		else $error("lock with illegal feedback");
	chk_sel_switch: assert property (i_sel[0] && !o_sel_active[0]
		|-> ##[1:40] o_sel_active[0])
		else $error("selector did not switch");
	chk_no_runt: assert property ($fell(o_sel_clk[0])
		|-> $past(o_sel_clk[0], 2))
		else $error("runt pulse on selector");
	cover property ($rose(o_lock));
	cover property ($rose(o_sel_active[0]));
	cover property (!$stable(eff));
endmodule
bind pcs_pll_ctrl pcs_pll_ctrl_assertions #(.LOCK_CNT(LOCK_CNT),
	.SEL_N(SEL_N)) chk (.i_ref_clk, .i_rst_n, .i_pll_rst, .i_fb_src,
	.i_static_delay, .i_dyn_delay_enable, .i_dyn_delay_zero_in,
	.i_dyn_delay_direction_in, .i_dyn_delay_value_in, .i_sel, .o_lock,
	.o_primary_clock_out, .o_shifted_clock_out, .o_dyn_delay_zero_out,
	.o_dyn_delay_direction_out, .o_dyn_delay_value_out, .o_sel_clk,
	.o_sel_active);
`default_nettype wire

// ===== tb/tb_top.sv
// bench for the synthesizer control: lock, delay, clocks, selectors
// assumes the user model supplies the reference and selector clocks
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pcs_pkg::*;
	logic clk, rst_n, prst, en, zr, dir, rc, fc, lock, pri, sft, dvd, oz, od;
	logic [2:0] val, ov;
	logic [7:0] sa, sb, sel, osc, act;
	pcs_fb_src_t src;
	pcs_div_t div;
	pcs_delay_t sd;
	logic [7:0] pat [3] = '{8'hff, 8'h55, 8'h00};
	int num_errors = 0;
	int comparisons = 0;
	int np, nd, nx, ns, p1;
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	pcs_user_model user (.i_clk(clk), .o_ref(rc), .o_fb(fc), .o_a(sa),
		.o_b(sb));
	pcs_pll_ctrl #(.LOCK_CNT(4), .SEL_N(8)) dut (.i_ref_clk(clk),
		.i_rst_n(rst_n), .i_pll_rst(prst), .i_reference_clock_in(rc),
		.i_feedback_clock_in(fc), .i_fb_src(src), .i_div(div),
		.i_static_delay(sd), .i_dyn_delay_enable(en),
		.i_dyn_delay_zero_in(zr), .i_dyn_delay_direction_in(dir),
		.i_dyn_delay_value_in(val), .i_sel_clk_a(sa), .i_sel_clk_b(sb),
		.i_sel(sel), .o_lock(lock), .o_primary_clock_out(pri),
		.o_shifted_clock_out(sft), .o_divided_clock_out(dvd),
		.o_dyn_delay_zero_out(oz), .o_dyn_delay_direction_out(od),
		.o_dyn_delay_value_out(ov), .o_sel_clk(osc), .o_sel_active(act));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_lock;
		for (int i = 0; i < 300 && lock !== 1'b1; i++)
			@(posedge clk);
		chk({7'h0, lock}, 8'h01);
	endtask
	// drive a pin setting, then give the synchroniser time to land
	task automatic set_dly(input logic e, z, d, input logic [2:0] v);
		en <= e;
		zr <= z;
		dir <= d;
		val <= v;
		cyc(4);
	endtask
	task automatic measure;
		logic pp, pd, ps;
		np = 0;
		nd = 0;
		nx = 0;
		ns = 0;
		pp = pri;
		pd = dvd;
		ps = osc[1];
		repeat (64) begin
			@(posedge clk);
			np += (pri !== pp);
			nd += (dvd !== pd);
			nx += (sft !== pri);
			ns += (osc[1] !== ps);
			pp = pri;
			pd = dvd;
			ps = osc[1];
		end
	endtask
	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		results();
	end
	initial begin
		{rst_n, prst, en, zr, dir, val, sel} = '0;
		src = FB_INTERNAL;
		div = {4{DIV_ONE}};
		sd = '0;
		cyc(12);
		rst_n <= 1'b1;
		cyc(3);
		wait_lock();
		prst <= 1'b1;
		cyc(4);
		chk({7'h0, lock}, 8'h00);
		prst <= 1'b0;
		wait_lock();
		for (int i = 0; i < 4; i++) begin
			set_dly(1'b1, i[0], i[1], 3'(i * 3 + 1));
			chk({7'h0, lock}, 8'h00);
			chk({3'h0, oz, od, ov}, {3'h0, i[0], i[1],
				i[0] ? 3'h0 : 3'(i * 3 + 1)});
			wait_lock();
		end
		sd <= '{zero: 1'b0, lead: 1'b1, value: 3'h5};
		set_dly(1'b0, 1'b1, 1'b0, 3'h2);
		chk({3'h0, oz, od, ov}, 8'h0d);
		set_dly(1'b1, 1'b1, 1'b0, 3'h3);
		wait_lock();
		measure();
		chk(8'(nx), 8'h00);
		p1 = np;
		div.post_div <= 8'h04;
		cyc(20);
		measure();
		chk({7'h0, np < p1}, 8'h01);
		div.sec_div <= 8'h04;
		cyc(20);
		measure();
		chk({7'h0, nd < np}, 8'h01);
		set_dly(1'b1, 1'b0, 1'b0, 3'h3);
		wait_lock();
		measure();
		p1 = nx;
		chk({7'h0, nx > 0}, 8'h01);
		set_dly(1'b1, 1'b0, 1'b1, 3'h3);
		wait_lock();
		measure();
		chk({7'h0, nx > 0}, 8'h01);
		chk({7'h0, nx != p1}, 8'h01);
		src <= FB_USER;
		cyc(3);
		wait_lock();
		src <= pcs_fb_src_t'(2'h3);
		cyc(30);
		chk({7'h0, lock}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			sel <= pat[i];
			cyc(60);
			chk(act, pat[i]);
			measure();
			chk(8'(ns), pat[i][1] ? 8'h08 : 8'h10);
		end
		results();
	end
endmodule
`default_nettype wire
